// ---- pkg/pba_consts.svh ----
// Constants of the peripheral bus access latency block
`ifndef PBA_CONSTS_SVH
`define PBA_CONSTS_SVH
// Window bounds, inclusive
`define PBA_SYS_LO 32'h4000_0000
`define PBA_SYS_HI 32'h4001_BFFF
`define PBA_SYSTEM_CONTROL_WINDOW_LO 32'h4001_E000
`define PBA_SYSTEM_CONTROL_WINDOW_HI 32'h4001_EFFF
`define PBA_PORT_LO 32'h4004_0000
`define PBA_PORT_HI 32'h4004_1FFF
`define PBA_WDT_LO 32'h4004_2000
`define PBA_WDT_HI 32'h4005_FFFF
// Latencies in reference clock cycles
`define PBA_LAT_SYS 6'h02
`define PBA_LAT_SYSTEM_CONTROL_WINDOW 6'h04
`define PBA_LAT_PB_EQ 6'h03
`define PBA_LAT_PB_FAST 6'h02
`define PBA_LAT_NONE 6'h02
`define PBA_LAT_WIDE 6'h02
`define PBA_CNT_LAST 6'h01
// Divider constants
`define PBA_DIV_ONE 4'h1
`define PBA_DIV_ZERO 4'h0
`endif

// ---- pkg/pba_pkg.sv ----
// Types of the peripheral bus access latency block
package pba_pkg;
    // Decoded window groups
    typedef enum logic [2:0] {
        PBA_G_NONE = 3'h0,
        PBA_G_SYS = 3'h1,
        PBA_G_SYSTEM_CONTROL_WINDOW = 3'h2,
        PBA_G_PORT = 3'h3,
        PBA_G_WDT = 3'h4
    } pba_grp_e;
    // Access sequencer, Gray along idle-sync-count
    typedef enum logic [1:0] {
        PBA_ST_IDLE = 2'h0,
        PBA_ST_SYNC = 2'h1,
        PBA_ST_COUNT = 2'h3
    } pba_state_e;
    // One bus request or forwarded access
    typedef struct packed {
        logic [31:0] addr;
        logic wr;
        logic wide;
        logic [31:0] wdata;
    } pba_req_s;
endpackage

// ---- rtl/pba_bridge.sv ----
// Peripheral bus decoder and access latency sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pba_consts.svh"
module pba_bridge #(
    parameter int DIV_W = 4,
    parameter int WAIT_W = 4
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Master side
    input wire logic i_req_valid,
    input wire pba_pkg::pba_req_s i_req,
    input wire logic i_contend,
    output logic o_req_ready,
    output logic o_ack,
    output logic [31:0] o_rdata,
    // Peripheral side
    output logic o_per_sel,
    output pba_pkg::pba_req_s o_per,
    input wire logic [WAIT_W-1:0] i_per_wait,
    input wire logic [31:0] i_per_rdata,
    // Clock ratio, core cycles per peripheral clock b cycle
    input wire logic [DIV_W-1:0] i_pclk_ratio
);
    import pba_pkg::*;

    pba_state_e state_q; // Sequencer state
    logic [5:0] cnt_q; // Remaining reference ticks
    logic pclk_unit_q; // Access counts in peripheral ticks
    logic map_q; // Latched access hit a window
    logic wr_q; // Latched access is a write
    logic [DIV_W-1:0] div_q; // Peripheral clock divider
    logic pclk_en_q; // Peripheral clock b enable pulse
    pba_grp_e grp_w; // Decoded group of incoming address
    logic acc_w; // Request accepted this cycle
    logic ratio_eq_w; // Core and peripheral clocks equal
    logic pclk_grp_w; // Group referenced to peripheral clock
    logic tick_w; // One reference clock elapsed
    logic [5:0] base_w; // Group latency
    logic [5:0] total_w; // Full latency of the access

    // Address decode, lowest address of each window inclusive
    always_comb
    begin
        if (i_req.addr >= `PBA_SYS_LO && i_req.addr <= `PBA_SYS_HI)
            grp_w = PBA_G_SYS;
        else if (i_req.addr >= `PBA_SYSTEM_CONTROL_WINDOW_LO && i_req.addr <= `PBA_SYSTEM_CONTROL_WINDOW_HI)
            grp_w = PBA_G_SYSTEM_CONTROL_WINDOW;
        else if (i_req.addr >= `PBA_PORT_LO && i_req.addr <= `PBA_PORT_HI)
            grp_w = PBA_G_PORT;
        else if (i_req.addr >= `PBA_WDT_LO && i_req.addr <= `PBA_WDT_HI)
            grp_w = PBA_G_WDT;
        else
            grp_w = PBA_G_NONE;
    end

    // Ratio of one or zero means the clocks run equal
    assign ratio_eq_w = (i_pclk_ratio <= `PBA_DIV_ONE);
    assign pclk_grp_w = (grp_w == PBA_G_PORT) || (grp_w == PBA_G_WDT);

    // Group latency in its own reference clock
    always_comb
    begin
        case (grp_w)
            PBA_G_SYS: base_w = `PBA_LAT_SYS;
            PBA_G_SYSTEM_CONTROL_WINDOW: base_w = `PBA_LAT_SYSTEM_CONTROL_WINDOW;
            PBA_G_PORT, PBA_G_WDT:
            begin
                // Faster core pays its sync wait in the sync state
                base_w = ratio_eq_w ? `PBA_LAT_PB_EQ : `PBA_LAT_PB_FAST;
            end
            default: base_w = `PBA_LAT_NONE;
        endcase
    end

    // Sum of bus, wide-register and module wait cycles
    always_comb
    begin
        total_w = base_w + 6'(i_per_wait);
        if (i_req.wide && grp_w != PBA_G_NONE)
            total_w = total_w + `PBA_LAT_WIDE;
    end

    // Contention from fetch or another master holds the request off
    assign acc_w = o_req_ready && i_req_valid && !i_contend;

    // Counting edge: core clock, or peripheral enable when slower
    assign tick_w = !pclk_unit_q || ratio_eq_w || pclk_en_q;

    // Peripheral clock b divider, a one-cycle enable
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_q <= '0;
            pclk_en_q <= 1'b0;
        end
        else if (ratio_eq_w || div_q >= i_pclk_ratio - DIV_W'(`PBA_DIV_ONE))
        begin
            div_q <= '0;
            pclk_en_q <= 1'b1;
        end
        else
        begin
            div_q <= div_q + DIV_W'(`PBA_DIV_ONE);
            pclk_en_q <= 1'b0;
        end
    end

    // Sequencer state
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            state_q <= PBA_ST_IDLE;
        else
        begin
            case (state_q)
                PBA_ST_IDLE:
                begin
                    // Slower peripheral clock needs a sync wait first
                    if (acc_w && pclk_grp_w && !ratio_eq_w)
                        state_q <= PBA_ST_SYNC;
                    else if (acc_w)
                        state_q <= PBA_ST_COUNT;
                end
                PBA_ST_SYNC:
                begin
                    // Always at least one peripheral tick passes here
                    if (pclk_en_q)
                        state_q <= PBA_ST_COUNT;
                end
                PBA_ST_COUNT:
                begin
                    if (tick_w && cnt_q == `PBA_CNT_LAST)
                        state_q <= PBA_ST_IDLE;
                end
                default: state_q <= PBA_ST_IDLE;
            endcase
        end
    end

    // Latency counter, loaded on accept
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt_q <= '0;
        else if (acc_w)
            cnt_q <= total_w;
        else if (state_q == PBA_ST_COUNT && tick_w)
            cnt_q <= cnt_q - `PBA_CNT_LAST;
    end

    // Attributes of the access in flight
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pclk_unit_q <= 1'b0;
            map_q <= 1'b0;
            wr_q <= 1'b0;
        end
        else if (acc_w)
        begin
            pclk_unit_q <= pclk_grp_w;
            map_q <= (grp_w != PBA_G_NONE);
            wr_q <= i_req.wr;
        end
    end

    // Ready drops on accept, returns with the answer
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_req_ready <= 1'b1;
        else if (acc_w)
            o_req_ready <= 1'b0;
        else if (state_q == PBA_ST_COUNT && tick_w && cnt_q == `PBA_CNT_LAST)
            o_req_ready <= 1'b1;
    end

    // Forward the access to the addressed window, one-cycle strobe
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_per_sel <= 1'b0;
            o_per <= '0;
        end
        else
        begin
            // Unmapped holes are never forwarded, so no module misbehaves
            o_per_sel <= acc_w && (grp_w != PBA_G_NONE);
            if (acc_w)
                o_per <= i_req;
        end
    end

    // Completion pulse and read data
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_ack <= 1'b0;
            o_rdata <= '0;
        end
        else if (state_q == PBA_ST_COUNT && tick_w && cnt_q == `PBA_CNT_LAST)
        begin
            o_ack <= 1'b1;
            // Unmapped reads answer zero rather than stalling
            o_rdata <= (map_q && !wr_q) ? i_per_rdata : '0;
        end
        else
        begin
            o_ack <= 1'b0;
            o_rdata <= '0;
        end
    end

    // Checks of the timing contract
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    // Plain accept with no module wait and no wide register
    sequence s_plain;
        acc_w && !i_req.wide && i_per_wait == '0;
    endsequence

    // Completion step: ack still low, then high one sample later
    sequence s_done;
        !o_ack ##1 o_ack;
    endsequence

    // Ack set at the N-th edge is seen by the sample after it
    sys_latency_a: assert property ((s_plain ##0 (grp_w == PBA_G_SYS))
        |-> ##1 !o_ack ##1 s_done)
        else $error("System window access not done in two cycles");
    system_control_window_latency_a: assert property ((s_plain ##0 (grp_w == PBA_G_SYSTEM_CONTROL_WINDOW))
        |-> ##4 s_done)
        else $error("System-control access not done in four cycles");
    port_equal_a: assert property ((s_plain ##0 (grp_w == PBA_G_PORT && ratio_eq_w))
        |-> ##3 s_done)
        else $error("Port window access not three cycles");
    wdt_equal_a: assert property ((s_plain ##0 (grp_w == PBA_G_WDT && ratio_eq_w))
        |-> ##3 s_done)
        else $error("Watchdog window access not three cycles");
    sync_added_a: assert property (acc_w && pclk_grp_w && !ratio_eq_w
        |=> state_q == PBA_ST_SYNC)
        else $error("Slow peripheral access skipped sync wait");
    wait_summed_a: assert property (acc_w && grp_w == PBA_G_SYS && !i_req.wide
        && i_per_wait == WAIT_W'(1) |-> ##3 s_done)
        else $error("Module wait not added to latency");
    wide_extra_a: assert property (acc_w && i_req.wide && i_per_wait == '0
        && grp_w == PBA_G_SYSTEM_CONTROL_WINDOW |-> ##6 s_done)
        else $error("Wide register access not two cycles longer");
    contend_hold_a: assert property (o_req_ready && i_contend |=> o_req_ready && !o_per_sel)
        else $error("Access started under contention");
    unmapped_zero_a: assert property (acc_w && grp_w == PBA_G_NONE && i_per_wait == '0
        |-> ##2 !o_ack ##1 (o_ack && o_rdata == '0))
        else $error("Unmapped access did not answer zero");
    forward_sel_a: assert property (acc_w && grp_w != PBA_G_NONE
        |=> o_per_sel && o_per.addr == $past(i_req.addr))
        else $error("Mapped access not forwarded");
endmodule
`default_nettype wire

// ---- verif/pba_periph_model.sv ----
// Behavioural model of the peripheral modules behind the bridge
`timescale 1ns/100ps
`default_nettype none
module pba_periph_model
(
    // Clock and strobes from the bridge
    input wire logic i_sys_clk,
    input wire logic i_per_sel,
    input wire logic i_ack,
    input wire pba_pkg::pba_req_s i_per,
    // Wait cycles chosen by the bench
    input wire logic [3:0] i_wait_cfg,
    // Answers to the bridge
    output logic [3:0] o_per_wait,
    output logic [31:0] o_per_rdata
);
    import pba_pkg::*;
    logic busy_q = 1'b0; // Access in flight
    logic [31:0] junk_q = 32'h0F0F_0F0F; // Idle bus pattern
    // Module wait cycles offered with every request
    assign o_per_wait = i_wait_cfg;
    // Busy from the strobe until completion
    always_ff @(posedge i_sys_clk)
    begin
        if (i_per_sel)
            busy_q <= 1'b1;
        else if (i_ack)
            busy_q <= 1'b0;
    end
    // Pattern moves every cycle so a stale sample never matches by luck
    always_ff @(posedge i_sys_clk)
    begin
        junk_q <= junk_q + 32'h1357_9BDF;
    end
    // Only forwarded windows answer; reserved holes never reach a module
    assign o_per_rdata = (i_per_sel || busy_q) ? (i_per.addr ^ 32'h5A5A_A5A5) : junk_q;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the peripheral bus access latency bridge
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pba_pkg::*;
    // Row: address, wr, wide, wait, ratio, count, strobe, ranged
    typedef struct packed {
        logic [31:0] addr;
        logic wr;
        logic wide;
        logic [3:0] w;
        logic [3:0] r;
        logic [5:0] n;
        logic sel;
        logic rg;
    } pba_row_s;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_req_valid = 1'b0;
    pba_req_s i_req = '0;
    logic i_contend = 1'b0;
    logic [3:0] i_pclk_ratio = 4'h1;
    logic [3:0] wait_cfg = 4'h0;
    logic o_req_ready, o_ack, o_per_sel;
    logic [31:0] o_rdata, per_rdata;
    logic [3:0] per_wait;
    pba_req_s o_per;
    int n_fail = 0;
    int checks_done = 0;
    pba_row_s rows [13];
    // 100 MHz clock
    always #5 i_sys_clk = ~i_sys_clk;
    pba_bridge i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
        .i_req(i_req), .i_contend(i_contend), .o_req_ready(o_req_ready), .o_ack(o_ack),
        .o_rdata(o_rdata), .o_per_sel(o_per_sel), .o_per(o_per), .i_per_wait(per_wait),
        .i_per_rdata(per_rdata), .i_pclk_ratio(i_pclk_ratio));
    pba_periph_model i_per (.i_sys_clk(i_sys_clk), .i_per_sel(o_per_sel), .i_ack(o_ack),
        .i_per(o_per), .i_wait_cfg(wait_cfg), .o_per_wait(per_wait), .o_per_rdata(per_rdata));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic complete_run();
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One access; latency counted from the accept edge
    task automatic access(input pba_req_s rq, input logic [3:0] w, input int hold,
        output int lat, output logic sel, output logic [31:0] rd);
        int k;
        k = 0;
        sel = 1'b0;
        @(posedge i_sys_clk);
        i_req <= rq;
        wait_cfg <= w;
        i_req_valid <= 1'b1;
        i_contend <= (hold > 0);
        #1;
        // Contention keeps the request waiting
        while (!(o_req_ready === 1'b1 && k >= hold))
        begin
            @(posedge i_sys_clk);
            k++;
            if (k == hold)
                i_contend <= 1'b0;
            if (k > 60)
            begin
                n_fail++;
                complete_run();
            end
            #1;
        end
        @(posedge i_sys_clk);
        i_req_valid <= 1'b0;
        // Strobe stands only in the cycle after the accept edge
        #1;
        sel = o_per_sel;
        // Bounded wait for completion
        for (lat = 1; lat < 60; lat++)
        begin
            @(posedge i_sys_clk);
            #1;
            if (o_ack === 1'b1)
                break;
        end
        // A lost answer counts as a mismatch and ends the run
        if (o_ack !== 1'b1)
        begin
            n_fail++;
            complete_run();
        end
        rd = o_rdata;
    endtask
    initial
    begin
        int lat;
        logic sel;
        logic ok;
        logic [31:0] rd;
        rows = '{{32'h4000_0000, 1'b0, 1'b0, 4'h0, 4'h1, 6'h02, 1'b1, 1'b0},
            {32'h4001_BFFF, 1'b1, 1'b0, 4'h1, 4'h0, 6'h03, 1'b1, 1'b0},
            {32'h4001_E000, 1'b0, 1'b0, 4'h0, 4'h1, 6'h04, 1'b1, 1'b0},
            {32'h4001_EFFF, 1'b0, 1'b1, 4'h0, 4'h1, 6'h06, 1'b1, 1'b0},
            {32'h4004_0000, 1'b0, 1'b0, 4'h0, 4'h1, 6'h03, 1'b1, 1'b0},
            {32'h4004_1FFF, 1'b0, 1'b0, 4'h2, 4'h1, 6'h05, 1'b1, 1'b0},
            {32'h4004_2000, 1'b1, 1'b0, 4'h0, 4'h1, 6'h03, 1'b1, 1'b0},
            {32'h4005_FFFF, 1'b0, 1'b1, 4'h0, 4'h0, 6'h05, 1'b1, 1'b0},
            {32'h4001_C000, 1'b0, 1'b1, 4'h0, 4'h1, 6'h02, 1'b0, 1'b0},
            {32'h4006_0000, 1'b0, 1'b0, 4'h0, 4'h1, 6'h02, 1'b0, 1'b0},
            {32'h4000_0000, 1'b0, 1'b0, 4'h0, 4'h3, 6'h02, 1'b1, 1'b0},
            {32'h4004_0000, 1'b0, 1'b0, 4'h0, 4'h2, 6'h02, 1'b1, 1'b1},
            {32'h4005_0000, 1'b0, 1'b1, 4'h1, 4'h3, 6'h05, 1'b1, 1'b1}};
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        // Table of ordinary accesses
        foreach (rows[i])
        begin
            @(posedge i_sys_clk);
            i_pclk_ratio <= rows[i].r;
            access({rows[i].addr, rows[i].wr, rows[i].wide, 32'hC3C3_3C3C}, rows[i].w, 0,
                lat, sel, rd);
            // Slow clock: sync wait of one to r cycles, then n peripheral ticks
            ok = (lat >= int'(rows[i].n) * int'(rows[i].r) + 1) &&
                (lat <= (int'(rows[i].n) + 1) * int'(rows[i].r));
            if (rows[i].rg)
                chk({31'h0, ok}, 32'h1);
            else
                chk(32'(lat), {26'h0, rows[i].n});
            chk({31'h0, sel}, {31'h0, rows[i].sel});
            chk(o_per.addr, rows[i].addr);
            chk(rd, (rows[i].sel && !rows[i].wr) ? rows[i].addr ^ 32'h5A5A_A5A5 : 32'h0);
        end
        // Contention holds acceptance, latency unchanged after it
        @(posedge i_sys_clk);
        i_pclk_ratio <= 4'h1;
        access({32'h4000_3000, 2'h0, 32'h0}, 4'h0, 3, lat, sel, rd);
        chk(32'(lat), 32'h2);
        // Back to back: second request taken in the completion cycle
        @(posedge i_sys_clk);
        i_req <= {32'h4000_0010, 2'h0, 32'h0};
        i_req_valid <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_req <= {32'h4000_0020, 2'h0, 32'h0};
        #1;
        chk({31'h0, o_ack}, 32'h1);
        @(posedge i_sys_clk);
        i_req_valid <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1;
        chk({31'h0, o_ack}, 32'h1);
        chk(o_per.addr, 32'h4000_0020);
        // Reset in mid-access
        @(posedge i_sys_clk);
        i_req <= {32'h4001_E100, 2'h0, 32'h0};
        i_req_valid <= 1'b1;
        @(posedge i_sys_clk);
        i_req_valid <= 1'b0;
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        #1;
        chk({29'h0, o_req_ready, o_ack, o_per_sel}, 32'h4);
        chk(o_rdata, 32'h0);
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        access({32'h4001_E000, 2'h0, 32'h0}, 4'h0, 0, lat, sel, rd);
        chk(32'(lat), 32'h4);
        complete_run();
    end
endmodule
`default_nettype wire
